/* hdl/tsba_pkg.sv */
// Shared constants and types for the time-slice bus arbiter.
// Assumes a single 250 MHz bus clock shared by every agent.
package tsba_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PRIO_SLOT = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // Priority slot fields and reset values
  // ----------------------------------------------------------------
  localparam int COUNT_LSB = 0;
  localparam int COUNT_W = 4;
  localparam int DRIVE_LSB = 4;
  localparam int DRIVE_W = 2;
  localparam logic [7:0] PRIO_SLOT_RESET = 8'h00;
  localparam logic [7:0] PRIO_SLOT_MASK = 8'h3f;
  localparam int CTRL_REQ_BIT = 0;

  // ----------------------------------------------------------------
  // Arbitration lines, queue and pipeline sizes
  // ----------------------------------------------------------------
  localparam int ARB_LINES = 4;
  localparam int CONT_LINE = 3;
  localparam int QUEUE_DEPTH = 4;
  localparam int PIPE_SLOTS = 3;
  localparam logic [2:0] QUEUE_FULL_CNT = 3'h4;
  localparam logic [1:0] PIPE_FULL_CNT = 2'h3;
  localparam logic [3:0] LAST_STEP = 4'hf;

  // Settle spans the registered line drive and the synchroniser delay
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STEP_SETTLE_PS = 24000;
  localparam logic [2:0] STEP_SETTLE_CYC =
    3'((STEP_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSBA_IDLE,
    TSBA_STEP,
    TSBA_END
  } tsba_state_t;

  typedef struct packed {
    logic [2:0] queue_count;
    logic [1:0] pipe_count;
    logic head_own;
    logic head_valid;
  } tsba_qstat_t;

endpackage

/* hdl/tsba_sync.sv */
// Three-stage synchroniser for the shared arbitration lines.
// Assumes asynchronous pin levels; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module tsba_sync #(
  parameter int WIDTH = 4
) (
  clock,
  reset,
  din,
  dout
);
  input wire logic clock;
  input wire logic reset;
  input wire logic [WIDTH-1:0] din;
  output logic [WIDTH-1:0] dout;

  // ----------------------------------------------------------------
  // Per-line capture chain
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    wire agree = (s2_reg == s3_reg);
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        out_reg <= 1'b0;
      end else begin
        s1_reg <= din[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (agree) begin
          out_reg <= s3_reg;
        end
      end
    end
    assign dout[i] = out_reg;
  end
endmodule

/* hdl/tsba_queue.sv */
// Local image of the shared four-entry grant queue and the request pipeline.
// Assumes every agent sees the same push events on the arbitration lines.
`timescale 1ns/1ps
module tsba_queue (
  clock,
  reset,
  push,
  push_own,
  retire,
  pop,
  stat
);
  input wire logic clock;
  input wire logic reset;
  input wire logic push;
  input wire logic push_own;
  input wire logic retire;
  output logic pop;
  output tsba_pkg::tsba_qstat_t stat;

  logic [tsba_pkg::QUEUE_DEPTH-1:0] own_reg;
  logic [2:0] count_reg;
  logic [1:0] pipe_reg;

  wire queue_full = (count_reg == tsba_pkg::QUEUE_FULL_CNT);
  wire pipe_full = (pipe_reg == tsba_pkg::PIPE_FULL_CNT);
  // Oldest entry moves on only when a pipeline slot is free
  assign pop = (count_reg != 3'h0) && (!pipe_full || retire);
  wire push_ok = push && (!queue_full || pop);
  wire [2:0] base = pop ? count_reg - 3'h1 : count_reg;

  // ----------------------------------------------------------------
  // Entry shift register, head at index 0
  // ----------------------------------------------------------------
  for (genvar i = 0; i < tsba_pkg::QUEUE_DEPTH; i++) begin : g_entry
    wire shifted = (pop && i < tsba_pkg::QUEUE_DEPTH - 1) ?
      own_reg[(i + 1) % tsba_pkg::QUEUE_DEPTH] : (pop ? 1'b0 : own_reg[i]);
    wire load = push_ok && (base == 3'(i));
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        own_reg[i] <= 1'b0;
      end else begin
        own_reg[i] <= load ? push_own : shifted;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 3'h0;
      pipe_reg <= 2'h0;
    end else begin
      count_reg <= base + {2'h0, push_ok};
      pipe_reg <= pipe_reg + {1'b0, pop} - {1'b0, retire && pipe_reg != 2'h0};
    end
  end

  assign stat.queue_count = count_reg;
  assign stat.pipe_count = pipe_reg;
  assign stat.head_own = own_reg[0];
  assign stat.head_valid = (count_reg != 3'h0);
endmodule

/* hdl/tsba_arbiter.sv */
// Time-slice bus arbiter of one bus agent, with its APB register slave.
// Assumes open-drain active-low arbitration lines resolved outside, and a
// same-clock retire pulse from the bus sequencer when a reply completes.
//
// Overview of operation
// - The own request enters the grant queue at the place set by step then line.
// - Requests leave the grant queue for the pipeline strictly in arrival order.
// - A period ends once every taking part agent is in the grant queue.
// - A new period starts the cycle after all four lines are seen released.
// - An agent with count k arbitrates in step k, count zero in step 0.
// - Drive 0, 1, 2 picks line 0, 1, 2, and lower lines enter first.
// - The chosen low line is held until the request is in the grant queue.
// - A later-step agent holds the continuation line until its own step.
// - A step ends only when all its agents are queued, stretched when full.
// - The pipeline holds at most three requests; entry needs a free slot.
// - The slot register is a two-bit drive field over a four-bit count.
// - The queue holds four; when full, arbitration freezes with lines held.
// - Only an agent ready in a period's first cycle takes part in it.
// - A period has at most sixteen steps, counts 0000 through 1111.
`timescale 1ns/1ps
module tsba_arbiter (
  clock,
  reset,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  arb_line_in,
  arb_line_out,
  arb_line_oe,
  pipe_retire,
  request_issue
);
  input wire logic clock;
  input wire logic reset;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [7:0] paddr;
  input wire logic [31:0] pwdata;
  output logic [31:0] prdata;
  output logic pready;
  output logic pslverr;
  input wire logic [3:0] arb_line_in;
  output logic [3:0] arb_line_out;
  output logic [3:0] arb_line_oe;
  input wire logic pipe_retire;
  output logic request_issue;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tsba_pkg::tsba_state_t state_reg;
  tsba_pkg::tsba_state_t state_next;
  logic [7:0] prio_slot_reg;
  logic pending_reg;
  logic joined_reg;
  logic queued_reg;
  logic [3:0] step_reg;
  logic [2:0] age_reg;
  logic [2:0] mask_reg;
  logic [3:0] oe_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic issue_reg;
  logic [3:0] line_out_reg;
  logic [3:0] line_seen;
  logic queue_pop;
  tsba_pkg::tsba_qstat_t qstat;

  // ----------------------------------------------------------------
  // Line sampling and shared queue image
  // ----------------------------------------------------------------
  tsba_sync #(
    .WIDTH(tsba_pkg::ARB_LINES)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .din(~arb_line_in),
    .dout(line_seen)
  );

  // Slot fields; reserved top bits are held at zero
  wire [3:0] my_count = prio_slot_reg[tsba_pkg::COUNT_LSB +: tsba_pkg::COUNT_W];
  wire [1:0] my_drive = prio_slot_reg[tsba_pkg::DRIVE_LSB +: tsba_pkg::DRIVE_W];
  // Drive 3 is not a line; it falls back to the lowest priority line
  wire [1:0] my_line = (my_drive == 2'h3) ? 2'h2 : my_drive;

  wire queue_full = (qstat.queue_count == tsba_pkg::QUEUE_FULL_CNT);
  wire in_step = (state_reg == tsba_pkg::TSBA_STEP);
  // A step is judged only after every line change has crossed the sync
  wire settled = (age_reg >= tsba_pkg::STEP_SETTLE_CYC);
  wire [2:0] live_low = line_seen[2:0] & ~mask_reg;

  // Highest priority live line wins this cycle's queue entry
  wire [1:0] win_line = live_low[0] ? 2'h0 : (live_low[1] ? 2'h1 : 2'h2);
  wire win_any = |live_low;
  // Frozen while full; a same-cycle pop frees room
  wire room = !queue_full || queue_pop;
  wire push = in_step && settled && win_any && room;
  wire my_turn = joined_reg && !queued_reg && (step_reg == my_count);
  wire my_driving = oe_reg[my_line];
  wire push_own = push && my_turn && my_driving && (win_line == my_line);

  // Step ends only when every low line has dropped
  wire low_clear = (line_seen[2:0] == 3'h0);
  wire all_clear = (line_seen == 4'h0);
  wire step_done = in_step && settled && low_clear && !win_any;
  wire step_last = (step_reg == tsba_pkg::LAST_STEP);
  wire period_done = step_done && (!line_seen[tsba_pkg::CONT_LINE] ||
    step_last);

  tsba_queue u_queue (
    .clock(clock),
    .reset(reset),
    .push(push),
    .push_own(push_own),
    .retire(pipe_retire),
    .pop(queue_pop),
    .stat(qstat)
  );

  // ----------------------------------------------------------------
  // Period sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tsba_pkg::TSBA_IDLE: begin
        if (all_clear) begin
          state_next = tsba_pkg::TSBA_STEP;
        end
      end
      tsba_pkg::TSBA_STEP: begin
        if (period_done) begin
          state_next = tsba_pkg::TSBA_END;
        end
      end
      tsba_pkg::TSBA_END: begin
        if (all_clear) begin
          state_next = tsba_pkg::TSBA_STEP;
        end
      end
      default: begin
        state_next = tsba_pkg::TSBA_IDLE;
      end
    endcase
  end

  wire period_start = (state_next == tsba_pkg::TSBA_STEP) && !in_step;
  wire step_next_go = step_done && !period_done;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= tsba_pkg::TSBA_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      step_reg <= 4'h0;
      age_reg <= 3'h0;
    end else if (period_start || step_next_go) begin
      step_reg <= period_start ? 4'h0 : step_reg + 4'h1;
      age_reg <= 3'h0;
    end else if (!settled) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  // A line that has entered stays masked until it is seen released
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mask_reg <= 3'h0;
    end else begin
      mask_reg <= (mask_reg & line_seen[2:0]) |
        (push ? (3'h1 << win_line) : 3'h0);
    end
  end

  // ----------------------------------------------------------------
  // Own participation and line drive
  // ----------------------------------------------------------------
  wire req_write = psel && penable && pwrite && !pready_reg &&
    (paddr == tsba_pkg::ADDR_CONTROL) && pwdata[tsba_pkg::CTRL_REQ_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pending_reg <= 1'b0;
      joined_reg <= 1'b0;
      queued_reg <= 1'b0;
    end else begin
      // Only requests ready at the period's first cycle join it
      if (period_start) begin
        joined_reg <= pending_reg;
        queued_reg <= 1'b0;
        pending_reg <= req_write;
      end else begin
        pending_reg <= pending_reg || req_write;
        if (push_own) begin
          queued_reg <= 1'b1;
        end
        if (period_done) begin
          joined_reg <= 1'b0;
        end
      end
    end
  end

  // Continuation line before the own step, own low line during it
  wire want_cont = joined_reg && !queued_reg && in_step &&
    (step_reg < my_count);
  wire want_low = my_turn && in_step && !push_own;
  wire [3:0] oe_next = (want_cont ? 4'h8 : 4'h0) |
    (want_low ? (4'h1 << my_line) : 4'h0);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      oe_reg <= 4'h0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // Own request leaves the queue head for the pipeline
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      issue_reg <= 1'b0;
    end else begin
      issue_reg <= queue_pop && qstat.head_own;
    end
  end

  // Open-drain data level is fixed low; only the enables switch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      line_out_reg <= 4'h0;
    end else begin
      line_out_reg <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  wire access = psel && penable && !pready_reg;
  wire hit_slot = (paddr == tsba_pkg::ADDR_PRIO_SLOT);
  wire hit_ctrl = (paddr == tsba_pkg::ADDR_CONTROL);
  wire hit_stat = (paddr == tsba_pkg::ADDR_STATUS);
  wire mapped = hit_slot || hit_ctrl || hit_stat;
  // Status word: line drive, participation, step and occupancy
  wire [31:0] status_word = {
    9'h000,
    qstat.queue_count,
    2'h0,
    qstat.pipe_count,
    step_reg,
    4'h0,
    queued_reg,
    joined_reg,
    pending_reg,
    in_step,
    oe_reg
  };
  wire [31:0] read_word =
    hit_slot ? {24'h000000, prio_slot_reg} :
    (hit_ctrl ? {31'h00000000, pending_reg} :
    (hit_stat ? status_word :
    32'h00000000));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      prio_slot_reg <= tsba_pkg::PRIO_SLOT_RESET;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access && !mapped;
      if (access && !pwrite) begin
        prdata_reg <= read_word;
      end
      if (access && pwrite && hit_slot) begin
        prio_slot_reg <= pwdata[7:0] & tsba_pkg::PRIO_SLOT_MASK;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign arb_line_oe = oe_reg;
  assign arb_line_out = line_out_reg;
  assign request_issue = issue_reg;
endmodule

/* dv/tsba_arbiter_properties.sv */
// Port checker for the time-slice bus arbiter.
// Assumes it is bound to tsba_arbiter and sees only its ports.
`timescale 1ns/1ps
module tsba_arbiter_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] arb_line_oe,
  input wire logic request_issue
);
  logic [5:0] slot_copy;
  wire [3:0] low_mask;
  wire slot_write;
  assign slot_write = psel && penable && pready && pwrite &&
    paddr == tsba_pkg::ADDR_PRIO_SLOT;
  // Line picked by the drive field, drive 3 folds onto line 2
  assign low_mask = (slot_copy[5:4] == 2'h3) ? 4'h4 : 4'h1 << slot_copy[5:4];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      slot_copy <= 6'h0;
    end else if (slot_write) begin
      slot_copy <= pwdata[5:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_answer: assert property (s_take |=> s_answer)
    else $error("ready not one cycle after take");
  a_err_addr: assert property (pready && pslverr |->
    !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("error on mapped address");
  a_err_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0)
    else $error("unmapped read not zero");
  a_slot_mask: assert property (
    pready && !pwrite && paddr == tsba_pkg::ADDR_PRIO_SLOT |->
    prdata[31:6] == 26'h0) else $error("slot high bits not zero");
  a_step_line: assert property (
    $rose(|arb_line_oe) && slot_copy[3:0] == 4'h0 |->
    arb_line_oe == low_mask) else $error("wrong line in step 0");
  a_later_cont: assert property (
    $rose(|arb_line_oe) && slot_copy[3:0] != 4'h0 |->
    arb_line_oe == 4'h8) else $error("later agent not on continuation");
  a_cont_to_low: assert property (
    $fell(arb_line_oe[3]) |-> arb_line_oe == low_mask)
    else $error("continuation not handed to own line");
  a_low_held: assert property (
    $rose(|arb_line_oe[2:0]) |-> (|arb_line_oe[2:0]) [*3])
    else $error("own line dropped early");
  a_line_release: assert property (
    $fell(|arb_line_oe[2:0]) |-> (arb_line_oe == 4'h0) [*3])
    else $error("line driven again after entry");
  a_one_line: assert property ($onehot0(arb_line_oe))
    else $error("more than one line driven");
  a_issue_pulse: assert property (request_issue |=> !request_issue)
    else $error("issue pulse too long");
endmodule

bind tsba_arbiter tsba_arbiter_checker u_chk (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .arb_line_oe(arb_line_oe),
  .request_issue(request_issue)
);

/* dv/tsba_peer_agents.sv */
// Model of the other agents sharing the arbitration lines.
// Assumes the bench resolves the open-drain lines from all pull enables.
`timescale 1ns/1ps
module tsba_peer_agents (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] pull_cmd,
  output logic [3:0] pull
);
  // Pulls change only on a clock edge, as a real agent's would
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pull <= 4'h0;
    end else begin
      pull <= pull_cmd;
    end
  end
endmodule

/* dv/test_time_slice_bus_arbiter.sv */
// Self-checking bench for the time-slice bus arbiter.
// Assumes the arbiter, its package and the peer model are compiled first.
`timescale 1ns/1ps
module test_time_slice_bus_arbiter;
  logic clock, reset, psel, penable, pwrite, pipe_retire;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, request_issue, er;
  logic [3:0] arb_line_in, arb_line_out, arb_line_oe, pull_cmd, peer_pull;
  int bad_count = 0;
  int tests_run = 0;
  int issues = 0;
  // Open-drain wire: low while any agent pulls
  assign arb_line_in = ~(arb_line_oe | peer_pull);

  tsba_arbiter dut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arb_line_in(arb_line_in),
    .arb_line_out(arb_line_out), .arb_line_oe(arb_line_oe),
    .pipe_retire(pipe_retire), .request_issue(request_issue)
  );
  tsba_peer_agents peer (
    .clock(clock), .reset(reset), .pull_cmd(pull_cmd), .pull(peer_pull)
  );

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (request_issue === 1'h1) issues <= issues + 1;
  end

  // ------
  // Shared tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail_wait;
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) fail_wait();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wait_oe(input logic [3:0] exp);
    int n;
    n = 0;
    while (arb_line_oe !== exp && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (arb_line_oe !== exp) fail_wait();
    check(32'(arb_line_oe), 32'(exp));
  endtask
  task automatic wait_issue(input int want);
    int n;
    n = 0;
    while (issues < want && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (issues < want) fail_wait();
    check(32'(issues), 32'(want));
  endtask
  task automatic req_step0;
    apb(1'h1, tsba_pkg::ADDR_CONTROL, 32'h1);
    wait_oe(4'h1);
    wait_oe(4'h0);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    apb(1'h0, tsba_pkg::ADDR_PRIO_SLOT, 32'h0);
    check(rd, 32'(tsba_pkg::PRIO_SLOT_RESET));
    check(32'(er), 32'h0);
    check(32'(arb_line_out), 32'h0);
    apb(1'h1, tsba_pkg::ADDR_PRIO_SLOT, 32'hffff_ffff);
    apb(1'h0, tsba_pkg::ADDR_PRIO_SLOT, 32'h0);
    check(rd, 32'(tsba_pkg::PRIO_SLOT_MASK));
    apb(1'h0, 8'h0c, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
  endtask
  task automatic t_step0;
    apb(1'h1, tsba_pkg::ADDR_PRIO_SLOT, 32'h0);
    req_step0();
    wait_issue(1);
  endtask
  task automatic t_later;
    apb(1'h1, tsba_pkg::ADDR_PRIO_SLOT, 32'h12);
    apb(1'h1, tsba_pkg::ADDR_CONTROL, 32'h1);
    wait_oe(4'h8);
    wait_oe(4'h2);
    wait_oe(4'h0);
    wait_issue(2);
  endtask
  task automatic t_pipe_full;
    apb(1'h1, tsba_pkg::ADDR_PRIO_SLOT, 32'h0);
    req_step0();
    wait_issue(3);
    req_step0();
    repeat (20) @(posedge clock);
    check(32'(issues), 32'h3);
    apb(1'h0, tsba_pkg::ADDR_STATUS, 32'h0);
    check(32'(rd[17:16]), 32'(tsba_pkg::PIPE_FULL_CNT));
    check(32'(rd[22:20]), 32'h1);
    pipe_retire <= 1'h1;
    @(posedge clock);
    pipe_retire <= 1'h0;
    wait_issue(4);
  endtask
  task automatic t_blocked;
    pull_cmd <= 4'h8;
    repeat (3) @(posedge clock);
    apb(1'h1, tsba_pkg::ADDR_CONTROL, 32'h1);
    repeat (30) @(posedge clock);
    check(32'(arb_line_oe), 32'h0);
    pull_cmd <= 4'h0;
    wait_oe(4'h1);
    wait_oe(4'h0);
  endtask

  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pipe_retire = 1'h0;
    pull_cmd = 4'h0;
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_regs();
    t_step0();
    t_later();
    t_pipe_full();
    t_blocked();
    conclude();
  end
endmodule
